// ===== core/dis_regs.vh
// Register map, strap addresses and timing constants of the dual bus control slave
// Overview of operation
// - Two independent slave ports reach registers and link
// - Strap selects one of eight primary addresses
// - Lines only pulled low, never driven high
// - SDA fall while SCL high starts transaction
// - SDA rise while SCL high ends transaction
// - Matching address acknowledged (remote ones only on link ack), otherwise left released
// - Local write bytes always acknowledged, remote ones only on link ack
// - Works at SCL rates up to 1 MHz
// - No access until 2 ms after power-up
// - Local register accesses never stretch the clock
// - Primary address readable at offset 0x00
// - Up to four extra per-receive-port addresses answered
// - Port address bypasses and keeps page select
// - Second port answers primary and port addresses
// - Second port remote reach set by 0x0C[7:4]
// - Reset control written only via primary port
// - Remote accesses stretch SCL until link answers
`ifndef DIS_REGS_VH
`define DIS_REGS_VH

`define DIS_OFF_PRIM 8'h00
`define DIS_OFF_RST 8'h01
`define DIS_OFF_MAP 8'h0c
`define DIS_OFF_PAGE 8'h4c
`define DIS_PAGE_HI 4'h5
`define DIS_PG_ALIAS 4'hc
`define DIS_RXID_HI 6'h3e
`define DIS_RST_SELF 0
`define DIS_MAP_LSB 4
`define DIS_MAP_RST 8'h00

`define DIS_STRAP_A0 7'h30
`define DIS_STRAP_A1 7'h32
`define DIS_STRAP_A2 7'h34
`define DIS_STRAP_A3 7'h36
`define DIS_STRAP_A4 7'h38
`define DIS_STRAP_A5 7'h3a
`define DIS_STRAP_A6 7'h3c
`define DIS_STRAP_A7 7'h3d

`define DIS_KIND_ADDR 2'h0
`define DIS_KIND_WR 2'h1
`define DIS_KIND_RD 2'h2

`define DIS_CLK_MHZ 200
`define DIS_PWRUP_MS 2

`endif

// ===== core/dis_top.v
// Dual bus control slave with local registers and back-channel forwarding
`timescale 1ns/1ps
`default_nettype none
`include "dis_regs.vh"
module dis_top #(
	parameter integer PWRUP_CYCLES = `DIS_PWRUP_MS * 1000 * `DIS_CLK_MHZ
) (
	// Clock and reset
	input wire i_sys_clk,
	input wire i_sys_rst,
	// Straps and power
	input wire i_power_down_pin,
	input wire [2:0] i_address_strap_pin,
	// Bus ports, index 0 is the primary port
	input wire [1:0] i_scl,
	input wire [1:0] i_sda,
	output reg [1:0] o_scl,
	output reg [1:0] o_scl_oe,
	output reg [1:0] o_sda,
	output reg [1:0] o_sda_oe,
	// Back-channel link
	input wire i_back_channel_link_clk,
	input wire i_back_channel_link_done,
	input wire i_back_channel_link_ack,
	input wire [7:0] i_back_channel_link_rdata,
	output reg o_back_channel_link_req,
	output reg [1:0] o_back_channel_link_rx_port,
	output reg [1:0] o_back_channel_link_kind,
	output reg [7:0] o_back_channel_link_data,
	// Status
	output reg o_ready
);
	localparam [8:0] S_IDLE = 9'h001;
	localparam [8:0] S_ADDR = 9'h002;
	localparam [8:0] S_AACK = 9'h004;
	localparam [8:0] S_WBYTE = 9'h008;
	localparam [8:0] S_WACK = 9'h010;
	localparam [8:0] S_RBYTE = 9'h020;
	localparam [8:0] S_RACK = 9'h040;
	localparam [8:0] S_RLOAD = 9'h080;
	localparam [8:0] S_WAIT = 9'h100;

	// Two-flop synchronisers plus one history stage for edges
	wire [18:0] raw = {i_scl, i_sda, i_power_down_pin, i_address_strap_pin, i_back_channel_link_clk,
		i_back_channel_link_done, i_back_channel_link_ack, i_back_channel_link_rdata};
	reg [18:0] sy1, sy2, sy3;
	always @(posedge i_sys_clk) begin
		sy1 <= raw;
		sy2 <= sy1;
		sy3 <= sy2;
	end
	wire [1:0] scl_s = sy2[18:17];
	wire [1:0] scl_d = sy3[18:17];
	wire [1:0] sda_s = sy2[16:15];
	wire [1:0] sda_d = sy3[16:15];
	wire pdn_s = sy2[14];
	wire [2:0] strap_s = sy2[13:11];
	wire lk_rise = sy2[10] & ~sy3[10];
	wire lk_done = sy2[9];
	wire lk_ack = sy2[8];
	wire [7:0] lk_rdata = sy2[7:0];

	// Register file
	reg [6:0] prim_addr;
	reg [7:0] rst_ctl;
	reg [7:0] remote_map;
	reg [1:0] page_sel;
	reg [6:0] rx_id [0:3];
	reg [7:0] page_mem [0:63];
	reg [18:0] pw_cnt;
	integer i;

	function [6:0] strap_addr;
		input [2:0] s;
		begin
			case (s)
				3'h0: strap_addr = `DIS_STRAP_A0;
				3'h1: strap_addr = `DIS_STRAP_A1;
				3'h2: strap_addr = `DIS_STRAP_A2;
				3'h3: strap_addr = `DIS_STRAP_A3;
				3'h4: strap_addr = `DIS_STRAP_A4;
				3'h5: strap_addr = `DIS_STRAP_A5;
				3'h6: strap_addr = `DIS_STRAP_A6;
				default: strap_addr = `DIS_STRAP_A7;
			endcase
		end
	endfunction

	// Returns {hit, remote, direct, rx_port}
	function [4:0] addr_match;
		input [6:0] a;
		input pt;
		integer n;
		begin
			addr_match = 5'h00;
			if (a == prim_addr)
				addr_match = 5'h10;
			for (n = 0; n < 4; n = n + 1) begin
				if (rx_id[n] != 7'h00 && a == rx_id[n])
					addr_match = {3'b101, n[1:0]};
				if (page_mem[n * 16 + `DIS_PG_ALIAS][6:0] != 7'h00 && a == page_mem[n * 16 + `DIS_PG_ALIAS][6:0]
					&& (!pt || remote_map[`DIS_MAP_LSB + n]))
					addr_match = {3'b110, n[1:0]};
			end
		end
	endfunction

	function [7:0] rd_reg;
		input [7:0] off;
		input [1:0] pg;
		begin
			if (off == `DIS_OFF_PRIM)
				rd_reg = {1'b0, prim_addr};
			else if (off == `DIS_OFF_RST)
				rd_reg = {rst_ctl[7:1], 1'b0};
			else if (off == `DIS_OFF_MAP)
				rd_reg = remote_map;
			else if (off == `DIS_OFF_PAGE)
				rd_reg = {6'h00, page_sel};
			else if (off[7:4] == `DIS_PAGE_HI)
				rd_reg = page_mem[{pg, off[3:0]}];
			else if (off[7:2] == `DIS_RXID_HI)
				rd_reg = {1'b0, rx_id[off[1:0]]};
			else
				rd_reg = 8'h00;
		end
	endfunction

	// Per-port signals gathered for the shared logic
	wire [1:0] wr_stb, want, sda_oe_w, scl_oe_w;
	wire [15:0] wr_off, wr_dat, req_dat;
	wire [5:0] wr_pg;
	wire [3:0] req_kind, req_rxp;
	reg [1:0] resp;
	reg resp_ack;
	reg [7:0] resp_data;

	genvar p;
	generate
		for (p = 0; p < 2; p = p + 1) begin : g_port
			reg [8:0] st, ret;
			reg [3:0] bitc;
			reg [7:0] sh, ptr, wo, wd, rdat;
			reg rnw, remote, direct, first, rel, sda_oe, scl_oe, stb, wnt;
			reg [1:0] rxp, kind;
			wire scl_r = scl_s[p] & ~scl_d[p];
			wire scl_f = ~scl_s[p] & scl_d[p];
			wire start = scl_s[p] & scl_d[p] & ~sda_s[p] & sda_d[p];
			wire stop = scl_s[p] & scl_d[p] & sda_s[p] & ~sda_d[p];
			wire [4:0] m = addr_match(sh[7:1], p == 1);
			wire [1:0] pg = direct ? rxp : page_sel;
			assign wr_stb[p] = stb;
			assign want[p] = wnt;
			assign sda_oe_w[p] = sda_oe;
			assign scl_oe_w[p] = scl_oe;
			assign wr_off[p * 8 +: 8] = wo;
			assign wr_dat[p * 8 +: 8] = wd;
			assign wr_pg[p * 3 +: 3] = {direct, rxp};
			assign req_dat[p * 8 +: 8] = rdat;
			assign req_kind[p * 2 +: 2] = kind;
			assign req_rxp[p * 2 +: 2] = rxp;

			task send_byte;
				input [7:0] b;
				begin
					sh <= b;
					sda_oe <= ~b[7];
					bitc <= 4'h0;
					st <= S_RBYTE;
				end
			endtask

			task stretch;
				input [1:0] k;
				input [7:0] d;
				input [8:0] r;
				begin
					wnt <= 1'b1;
					kind <= k;
					rdat <= d;
					scl_oe <= 1'b1;
					ret <= r;
					st <= S_WAIT;
				end
			endtask

			task read_load;
				begin
					if (remote) begin
						stretch(`DIS_KIND_RD, 8'h00, S_RBYTE);
					end else begin
						send_byte(rd_reg(ptr, pg));
						ptr <= ptr + 8'h01;
					end
				end
			endtask

			always @(posedge i_sys_clk) begin
				stb <= 1'b0;
				if (i_sys_rst || !o_ready) begin
					st <= S_IDLE;
					ret <= S_IDLE;
					bitc <= 4'h0;
					sh <= 8'h00;
					ptr <= 8'h00;
					wo <= 8'h00;
					wd <= 8'h00;
					rdat <= 8'h00;
					rnw <= 1'b0;
					remote <= 1'b0;
					direct <= 1'b0;
					first <= 1'b0;
					rel <= 1'b0;
					sda_oe <= 1'b0;
					scl_oe <= 1'b0;
					wnt <= 1'b0;
					rxp <= 2'h0;
					kind <= 2'h0;
				end else if (rel) begin
					scl_oe <= 1'b0;
					rel <= 1'b0;
				end else if (start && !scl_oe) begin
					st <= S_ADDR;
					bitc <= 4'h0;
					sda_oe <= 1'b0;
				end else if (stop && !scl_oe) begin
					st <= S_IDLE;
					sda_oe <= 1'b0;
				end else begin
					case (st)
						S_ADDR: begin
							if (scl_r) begin
								sh <= {sh[6:0], sda_s[p]};
								bitc <= bitc + 4'h1;
							end else if (scl_f && bitc == 4'h8) begin
								rnw <= sh[0];
								remote <= m[3];
								direct <= m[2];
								rxp <= m[1:0];
								first <= 1'b1;
								if (!m[4])
									st <= S_IDLE;
								else if (m[3])
									stretch(`DIS_KIND_ADDR, sh, S_AACK);
								else begin
									sda_oe <= 1'b1;
									st <= S_AACK;
								end
							end
						end
						S_AACK: begin
							if (scl_f) begin
								sda_oe <= 1'b0;
								bitc <= 4'h0;
								if (rnw)
									read_load;
								else
									st <= S_WBYTE;
							end
						end
						S_WBYTE: begin
							if (scl_r) begin
								sh <= {sh[6:0], sda_s[p]};
								bitc <= bitc + 4'h1;
							end else if (scl_f && bitc == 4'h8) begin
								if (remote)
									stretch(`DIS_KIND_WR, sh, S_WACK);
								else begin
									if (first) begin
										ptr <= sh;
										first <= 1'b0;
									end else begin
										stb <= 1'b1;
										wo <= ptr;
										wd <= sh;
										ptr <= ptr + 8'h01;
									end
									sda_oe <= 1'b1;
									st <= S_WACK;
								end
							end
						end
						S_WACK: begin
							if (scl_f) begin
								sda_oe <= 1'b0;
								bitc <= 4'h0;
								st <= S_WBYTE;
							end
						end
						S_RBYTE: begin
							if (scl_f) begin
								if (bitc == 4'h7) begin
									sda_oe <= 1'b0;
									st <= S_RACK;
								end else begin
									sh <= {sh[6:0], 1'b0};
									sda_oe <= ~sh[6];
									bitc <= bitc + 4'h1;
								end
							end
						end
						S_RACK: begin
							if (scl_r)
								st <= sda_s[p] ? S_IDLE : S_RLOAD;
						end
						S_RLOAD: begin
							if (scl_f)
								read_load;
						end
						S_WAIT: begin
							if (resp[p]) begin
								wnt <= 1'b0;
								rel <= 1'b1;
								if (ret == S_RBYTE)
									send_byte(resp_data);
								else if (resp_ack) begin
									sda_oe <= 1'b1;
									st <= ret;
								end else
									st <= S_IDLE;
							end
						end
						default: st <= S_IDLE;
					endcase
				end
			end
		end
	endgenerate

	// Power-up delay, strap capture and register writes
	reg p1v;
	reg [7:0] p1o, p1d;
	reg [2:0] p1g;
	wire wv = wr_stb[0] | p1v;
	wire [7:0] wo_m = wr_stb[0] ? wr_off[7:0] : p1o;
	wire [7:0] wd_m = wr_stb[0] ? wr_dat[7:0] : p1d;
	wire [2:0] wg_m = wr_stb[0] ? wr_pg[2:0] : p1g;
	wire [1:0] wpg = wg_m[2] ? wg_m[1:0] : page_sel;

	always @(posedge i_sys_clk) begin
		if (i_sys_rst || !pdn_s) begin
			pw_cnt <= 19'h00000;
			o_ready <= 1'b0;
			prim_addr <= `DIS_STRAP_A0;
			rst_ctl <= 8'h00;
			remote_map <= `DIS_MAP_RST;
			page_sel <= 2'h0;
			p1v <= 1'b0;
			p1o <= 8'h00;
			p1d <= 8'h00;
			p1g <= 3'h0;
			for (i = 0; i < 4; i = i + 1)
				rx_id[i] <= 7'h00;
			for (i = 0; i < 64; i = i + 1)
				page_mem[i] <= 8'h00;
		end else begin
			if (!o_ready) begin
				pw_cnt <= pw_cnt + 19'h00001;
				if (pw_cnt == PWRUP_CYCLES[18:0] - 19'h00001) begin
					o_ready <= 1'b1;
					prim_addr <= strap_addr(strap_s);
				end
			end
			if (wr_stb[1]) begin
				p1v <= 1'b1;
				p1o <= wr_off[15:8];
				p1d <= wr_dat[15:8];
				p1g <= wr_pg[5:3];
			end else if (!wr_stb[0])
				p1v <= 1'b0;
			if (rst_ctl[`DIS_RST_SELF]) begin
				rst_ctl[`DIS_RST_SELF] <= 1'b0;
				remote_map <= `DIS_MAP_RST;
				page_sel <= 2'h0;
				prim_addr <= strap_addr(strap_s);
				for (i = 0; i < 4; i = i + 1)
					rx_id[i] <= 7'h00;
			end else if (wv) begin
				if (wo_m == `DIS_OFF_PRIM)
					prim_addr <= wd_m[6:0];
				else if (wo_m == `DIS_OFF_RST) begin
					if (wr_stb[0])
						rst_ctl <= wd_m;
				end else if (wo_m == `DIS_OFF_MAP)
					remote_map <= wd_m;
				else if (wo_m == `DIS_OFF_PAGE) begin
					if (!wg_m[2])
						page_sel <= wd_m[1:0];
				end else if (wo_m[7:4] == `DIS_PAGE_HI)
					page_mem[{wpg, wo_m[3:0]}] <= wd_m;
				else if (wo_m[7:2] == `DIS_RXID_HI)
					rx_id[wo_m[1:0]] <= wd_m[6:0];
			end
		end
	end

	// Back-channel arbiter, primary port first
	reg busy, owner;
	always @(posedge i_sys_clk) begin
		resp <= 2'b00;
		if (i_sys_rst || !o_ready) begin
			busy <= 1'b0;
			owner <= 1'b0;
			resp_ack <= 1'b0;
			resp_data <= 8'h00;
			o_back_channel_link_req <= 1'b0;
			o_back_channel_link_rx_port <= 2'h0;
			o_back_channel_link_kind <= 2'h0;
			o_back_channel_link_data <= 8'h00;
		end else if (!busy) begin
			if (!lk_done && want != 2'b00) begin
				owner <= ~want[0];
				busy <= 1'b1;
				o_back_channel_link_req <= 1'b1;
				o_back_channel_link_kind <= want[0] ? req_kind[1:0] : req_kind[3:2];
				o_back_channel_link_rx_port <= want[0] ? req_rxp[1:0] : req_rxp[3:2];
				o_back_channel_link_data <= want[0] ? req_dat[7:0] : req_dat[15:8];
			end
		end else if (o_back_channel_link_req) begin
			if (lk_done && lk_rise) begin
				o_back_channel_link_req <= 1'b0;
				resp[owner] <= 1'b1;
				resp_ack <= lk_ack;
				resp_data <= lk_rdata;
			end
		end else if (!lk_done)
			busy <= 1'b0;
	end

	// Open-drain pins: driven value is always low
	always @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_sda <= 2'b00;
			o_scl <= 2'b00;
			o_sda_oe <= 2'b00;
			o_scl_oe <= 2'b00;
		end else begin
			o_sda <= 2'b00;
			o_scl <= 2'b00;
			o_sda_oe <= sda_oe_w;
			o_scl_oe <= scl_oe_w;
		end
	end
endmodule
`default_nettype wire

// ===== bench/dis_top_props.sv
// Concurrent checks on the ports of the dual control slave
`timescale 1ns/1ps
`default_nettype none
module dis_top_props #(
	parameter integer PWRUP_CYCLES = 400000
) (
	// Clock, reset, power
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_power_down_pin,
	// Bus
	input wire logic [1:0] i_scl,
	input wire logic [1:0] o_scl,
	input wire logic [1:0] o_scl_oe,
	input wire logic [1:0] o_sda,
	input wire logic [1:0] o_sda_oe,
	// Link and status
	input wire logic i_back_channel_link_done,
	input wire logic o_back_channel_link_req,
	input wire logic [1:0] o_back_channel_link_rx_port,
	input wire logic [1:0] o_back_channel_link_kind,
	input wire logic [7:0] o_back_channel_link_data,
	input wire logic o_ready
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	wire req = o_back_channel_link_req;
	wire done = i_back_channel_link_done;
	integer up_cnt = 0;
	always @(posedge i_sys_clk) begin
		if (i_sys_rst || !i_power_down_pin) begin
			up_cnt <= 0;
		end else begin
			up_cnt <= up_cnt + 1;
		end
	end
	chk_never_high: assert property (o_scl == 2'h0 && o_sda == 2'h0) else $error("line driven high");
	chk_quiet_early: assert property (!o_ready |-> o_sda_oe == 2'h0 && o_scl_oe == 2'h0)
		else $error("bus pulled before ready");
	chk_ready_delay: assert property ($rose(o_ready) |-> up_cnt >= PWRUP_CYCLES)
		else $error("ready too early");
	chk_stretch_remote: assert property ($rose(|o_scl_oe) |-> ##[0:3] req)
		else $error("clock stretched without link request");
	chk_stretch_hold: assert property (req && $past(req) |-> o_scl_oe != 2'h0)
		else $error("clock released during link wait");
	chk_req_stable: assert property (req && $past(req) |-> $stable({o_back_channel_link_kind,
		o_back_channel_link_data, o_back_channel_link_rx_port})) else $error("pending request changed");
	chk_req_answered: assert property ($fell(req) |-> $past(done, 2))
		else $error("request dropped without answer");
	chk_req_idle: assert property ($rose(req) |-> !done && !$past(done))
		else $error("request raised while answer still up");
	chk_sda_scl_low: assert property ($changed(o_sda_oe[0]) |-> !i_scl[0])
		else $error("data moved while clock high");
	cov_link: cover property ($rose(req));
	cov_ready: cover property ($rose(o_ready));
	cov_ack_second: cover property ($rose(o_sda_oe[1]));
endmodule
bind dis_top dis_top_props #(.PWRUP_CYCLES(PWRUP_CYCLES)) i_dis_top_props (.*);
`default_nettype wire

// ===== bench/dis_host.sv
// Bus master model pulling one open-drain control port
`timescale 1ns/1ps
`default_nettype none
module dis_host (
	// Clock and resolved lines
	input wire logic i_sys_clk,
	input wire logic i_scl,
	input wire logic i_sda,
	// Pulls, high pulls the line low
	output logic o_scl_low,
	output logic o_sda_low
);
	localparam int Q = 20;
	initial begin
		o_scl_low = 1'b0;
		o_sda_low = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask
	task automatic start();
		o_sda_low = 1'b0;
		w(Q);
		o_scl_low = 1'b0;
		w(Q);
		o_sda_low = 1'b1;
		w(Q);
		o_scl_low = 1'b1;
		w(Q);
	endtask
	task automatic stop();
		o_sda_low = 1'b1;
		w(Q);
		o_scl_low = 1'b0;
		w(Q);
		o_sda_low = 1'b0;
		w(Q);
	endtask
	task automatic bt(input logic b, output logic r);
		int n;
		o_sda_low = ~b;
		w(Q);
		o_scl_low = 1'b0;
		n = 0;
		while (i_scl !== 1'b1 && n < 3000) begin
			w(1);
			n++;
		end
		w(Q);
		r = i_sda;
		o_scl_low = 1'b1;
	endtask
	task automatic xb(input logic [7:0] d, input logic m, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) bt(d[i], r[i]);
		bt(m, a);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic nak);
		logic [7:0] r;
		logic k0, k1, k2;
		start();
		xb({a, 1'b0}, 1'b1, r, k0);
		xb(p, 1'b1, r, k1);
		xb(d, 1'b1, r, k2);
		stop();
		nak = k0 | k1 | k2;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d, output logic nak);
		logic [7:0] r;
		logic k0, k1, k2, k3;
		start();
		xb({a, 1'b0}, 1'b1, r, k0);
		xb(p, 1'b1, r, k1);
		start();
		xb({a, 1'b1}, 1'b1, r, k2);
		xb(8'hff, 1'b1, d, k3);
		stop();
		nak = k0 | k1 | k2;
	endtask
endmodule
`default_nettype wire

// ===== bench/dis_top_tb_top.sv
// Self-checking bench for the dual control slave
`timescale 1ns/1ps
`default_nettype none
module dis_top_tb_top;
	typedef struct packed {logic p; logic [6:0] wa; logic [7:0] wp; logic [7:0] wd; logic nk; logic [7:0] rp;
		logic [7:0] ex;} dis_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic lclk = 1'b0;
	logic done = 1'b0;
	logic ack = 1'b0;
	logic nak;
	logic [7:0] rdata = 8'h5a;
	logic [7:0] last = 8'h00;
	logic [7:0] rv;
	logic [7:0] lk = 8'h00;
	logic pdn = 1'b1;
	logic [2:0] strap = 3'h7;
	wire [1:0] scl_oe, sda_oe, h_scl, h_sda;
	wire [1:0] scl = ~(h_scl | scl_oe);
	wire [1:0] sda = ~(h_sda | sda_oe);
	wire req, ready;
	wire [7:0] data;
	wire [1:0] kind, rxp;
	int bad_count = 0;
	int checks = 0;
	int cyc = 0;
	int nreq = 0;
	int wc = 0;
	dis_row_t rows [8] = '{
		'{1'b0, 7'h3d, 8'h0c, 8'hf0, 1'b0, 8'h0c, 8'hf0},
		'{1'b0, 7'h30, 8'h0c, 8'h55, 1'b1, 8'h0c, 8'hf0},
		'{1'b1, 7'h3d, 8'h01, 8'h01, 1'b0, 8'h0c, 8'hf0},
		'{1'b1, 7'h3d, 8'h00, 8'h3d, 1'b0, 8'h00, 8'h3d},
		'{1'b0, 7'h3d, 8'h01, 8'h01, 1'b0, 8'h0c, 8'h00},
		'{1'b0, 7'h3d, 8'hf8, 8'h50, 1'b0, 8'hf8, 8'h50},
		'{1'b0, 7'h50, 8'h4c, 8'h03, 1'b0, 8'h4c, 8'h00},
		'{1'b1, 7'h50, 8'h5c, 8'h44, 1'b0, 8'h5c, 8'h44}};
	dis_top #(.PWRUP_CYCLES(2000)) i_dis_top (
		.i_sys_clk(clk), .i_sys_rst(rst), .i_power_down_pin(pdn), .i_address_strap_pin(strap),
		.i_scl(scl), .i_sda(sda), .o_scl(), .o_scl_oe(scl_oe), .o_sda(), .o_sda_oe(sda_oe),
		.i_back_channel_link_clk(lclk), .i_back_channel_link_done(done), .i_back_channel_link_ack(ack),
		.i_back_channel_link_rdata(rdata), .o_back_channel_link_req(req), .o_back_channel_link_rx_port(rxp),
		.o_back_channel_link_kind(kind), .o_back_channel_link_data(data), .o_ready(ready));
	dis_host i_host0 (.i_sys_clk(clk), .i_scl(scl[0]), .i_sda(sda[0]), .o_scl_low(h_scl[0]), .o_sda_low(h_sda[0]));
	// Second processor on its own port
	dis_host i_host1 (.i_sys_clk(clk), .i_scl(scl[1]), .i_sda(sda[1]),
		.o_scl_low(h_scl[1]), .o_sda_low(h_sda[1]));
	always #2.5 clk = ~clk;
	// Link clock runs only while a request is out
	always #40 lclk = req ? ~lclk : 1'b0;
	always @(negedge clk) begin
		if (req && !done) begin
			wc <= wc + 1;
			if (wc == 30) begin
				done <= 1'b1;
				ack <= 1'b1;
				rdata <= 8'ha5;
				last <= data;
				lk <= {4'h0, rxp, kind};
				nreq <= nreq + 1;
			end
		end else if (!req && done) begin
			done <= 1'b0;
			ack <= 1'b0;
			rdata <= 8'h5a;
			wc <= 0;
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			bad_count++;
			test_done();
		end
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic p, input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
		if (p) i_host1.wr(a, r, d, nak);
		else i_host0.wr(a, r, d, nak);
	endtask
	task automatic rd(input logic p, input logic [6:0] a, input logic [7:0] r);
		if (p) i_host1.rd(a, r, rv, nak);
		else i_host0.rd(a, r, rv, nak);
	endtask
	initial begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		wr(0, 7'h3d, 8'h0c, 8'hf0);
		check({7'h0, nak}, 8'h01, "early access");
		for (int i = 0; i < 3000 && ready !== 1'b1; i++) @(negedge clk);
		check({7'h0, ready}, 8'h01, "ready");
		$display("power-up done");
		foreach (rows[k]) begin
			wr(rows[k].p, rows[k].wa, rows[k].wp, rows[k].wd);
			check({7'h0, nak}, {7'h0, rows[k].nk}, "write ack");
			rd(rows[k].p, 7'h3d, rows[k].rp);
			check(rv, rows[k].ex, "read back");
			$display("row %0d done", k);
		end
		wr(1, 7'h44, 8'h12, 8'h5a);
		check({7'h0, nak}, 8'h01, "blocked remote");
		check(nreq[7:0], 8'h00, "no link request");
		wr(0, 7'h3d, 8'h0c, 8'h10);
		wr(1, 7'h44, 8'h12, 8'h5a);
		check({7'h0, nak}, 8'h00, "remote write");
		check(last, 8'h5a, "link data");
		check(nreq[7:0], 8'h03, "link requests");
		check(lk, 8'h01, "link kind write");
		rd(0, 7'h44, 8'h12);
		check({7'h0, nak}, 8'h00, "remote read ack");
		check(rv, 8'ha5, "remote read");
		check(lk, 8'h02, "link kind read");
		$display("remote done");
		// Power pin cycle with a new strap value
		pdn = 1'b0;
		strap = 3'h3;
		repeat (4) @(negedge clk);
		check({7'h0, ready}, 8'h00, "ready dropped");
		pdn = 1'b1;
		wr(0, 7'h36, 8'h0c, 8'h20);
		check({7'h0, nak}, 8'h01, "early after power");
		for (int i = 0; i < 3000 && ready !== 1'b1; i++) @(negedge clk);
		check({7'h0, ready}, 8'h01, "ready again");
		rd(0, 7'h36, 8'h00);
		check({7'h0, nak}, 8'h00, "strap ack");
		check(rv, 8'h36, "strap address");
		$display("power cycle done");
		test_done();
	end
endmodule
`default_nettype wire
